// file: memory_map_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module memory_map_decoder_tb;
  localparam logic [2:0] FE = 3'h1;
  localparam logic [2:0] CR = 3'h2;
  localparam logic [2:0] DR = 3'h3;
  localparam logic [2:0] DW = 3'h4;
  localparam logic [5:0] PF = mmd_pkg::MMD_T_PFLASH;
  localparam logic [5:0] DF = mmd_pkg::MMD_T_DFLASH;
  localparam logic [5:0] SR = mmd_pkg::MMD_T_SRAM;
  localparam logic [5:0] BT = mmd_pkg::MMD_T_BOOT;
  localparam logic [5:0] EX = mmd_pkg::MMD_T_EXT;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b1;
  logic ce = 1'b1;
  logic prog = 1'b0;
  logic ext_only = 1'b0;
  logic [2:0] op = 3'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [7:0] ra = 8'h00;
  logic ri = 1'b0;
  logic [7:0] rwd = 8'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  mmd_pkg::mmd_req_t req;
  logic [5:0] tgt;
  logic [15:0] maddr;
  logic wr_ok, wr_block, ext_cyc;
  logic [7:0] port_lo, rdata;
  int miscompares = 0;
  int cmp_count = 0;
  int pm_kb [8] = '{0, 0, 16, 24, 28, 30, 31, 32};
  int pm;

  mmd_core_model i_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .op_i(op), .addr_i(addr),
    .wdata_i(wd), .req_o(req));
  mmd_decoder i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .prog_mode_i(prog),
    .ext_only_i(ext_only), .req_i(req), .tgt_o(tgt), .maddr_o(maddr), .wr_ok_o(wr_ok),
    .wr_block_o(wr_block), .ext_cyc_o(ext_cyc), .port_lo_o(port_lo), .reg_addr_i(ra),
    .reg_ind_i(ri), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata));

  // free-running core clock
  always #10 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one core request, target judged in the answer cycle
  task automatic mem(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d,
                     input logic [5:0] e);
    @(posedge clk_i);
    op <= o;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    op <= 3'h0;
    #1;
    chk("tgt_o", 16'(e), 16'(tgt));
  endtask : mem

  // register write; only defined offsets are ever written
  task automatic rw(input logic [7:0] a, input logic i, input logic [7:0] d, input logic p);
    @(posedge clk_i);
    ra <= a;
    ri <= i;
    rwd <= d;
    rwr <= 1'b1;
    prog <= p;
    @(posedge clk_i);
    rwr <= 1'b0;
    prog <= 1'b0;
  endtask : rw

  task automatic rr(input logic [7:0] a, input logic i, input logic [7:0] e);
    @(posedge clk_i);
    ra <= a;
    ri <= i;
    rrd <= 1'b1;
    @(posedge clk_i);
    rrd <= 1'b0;
    #1;
    chk("reg_rdata_o", 16'(e), 16'(rdata));
  endtask : rr

  task automatic t_regs();
    rr(8'hfe, 1'b0, 8'h07);
    rr(8'hff, 1'b0, 8'h03);
    rr(8'h8f, 1'b0, 8'h00);
    rr(8'h90, 1'b0, 8'h00);
    rw(8'hfe, 1'b0, 8'h06, 1'b0);
    rr(8'hfe, 1'b0, 8'h07);
    rw(8'hfe, 1'b0, 8'h06, 1'b1);
    rr(8'hfe, 1'b0, 8'h06);
    rw(8'hfe, 1'b0, 8'h07, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_map();
    mem(DR, 16'h0000, 8'h00, SR);
    mem(DR, 16'h03ff, 8'h00, SR);
    mem(FE, 16'h7fff, 8'h00, PF);
    mem(FE, 16'h8000, 8'h00, EX);
    chk("ext_cyc_o", 16'h0000, 16'(ext_cyc));
    mem(CR, 16'h8000, 8'h00, EX);
    mem(DW, 16'h9000, 8'ha5, EX);
    chk("port_lo_o", 16'h0000, 16'(port_lo));
    @(posedge clk_i);
    ext_only <= 1'b1;
    mem(FE, 16'h0000, 8'h00, EX);
    ext_only <= 1'b0;
    $display("test map done");
  endtask : t_map

  task automatic t_part();
    for (int c = 0; c < 8; c++) begin
      pm = pm_kb[c] * 1024;
      rw(8'hfe, 1'b0, 8'(c), 1'b1);
      if (pm == 0) begin
        mem(FE, 16'h0000, 8'h00, EX);
      end else begin
        mem(FE, 16'(pm - 1), 8'h00, PF);
        mem(FE, 16'(pm), 8'h00, EX);
      end
      if (pm < 32768) begin
        mem(DR, 16'(32768 - pm + 1023), 8'h00, DF);
      end
    end
    rw(8'hfe, 1'b0, 8'h07, 1'b1);
    $display("test partition done");
  endtask : t_part

  task automatic t_ext();
    rw(8'hff, 1'b0, 8'h00, 1'b1);
    mem(DW, 16'h9000, 8'ha5, EX);
    chk("ext_cyc_o", 16'h0001, 16'(ext_cyc));
    chk("port_lo_o", 16'h00a5, 16'(port_lo));
    mem(DW, 16'h0010, 8'h5a, SR);
    chk("port_lo_o", 16'h0000, 16'(port_lo));
    rw(8'hff, 1'b0, 8'h03, 1'b1);
    $display("test external done");
  endtask : t_ext

  task automatic wchk(input logic [15:0] a, input logic [5:0] e, input logic blk);
    mem(DW, a, 8'h3c, e);
    chk("wr_block_o", 16'(blk), 16'(wr_block));
    chk("wr_ok_o", 16'(!blk), 16'(wr_ok));
  endtask : wchk

  task automatic t_write();
    wchk(16'h0800, PF, 1'b1);
    rw(8'h8f, 1'b0, 8'h01, 1'b0);
    wchk(16'h0800, PF, 1'b0);
    rw(8'hfe, 1'b0, 8'h27, 1'b1);
    wchk(16'h0fff, PF, 1'b1);
    wchk(16'h1000, PF, 1'b0);
    rw(8'hfe, 1'b0, 8'h67, 1'b1);
    wchk(16'h7fff, PF, 1'b1);
    rw(8'hfe, 1'b0, 8'h86, 1'b1);
    wchk(16'h0400, DF, 1'b0);
    wchk(16'h2000, PF, 1'b1);
    rw(8'hfe, 1'b0, 8'h07, 1'b1);
    rw(8'h8f, 1'b0, 8'h00, 1'b0);
    $display("test write done");
  endtask : t_write

  task automatic t_misc();
    rw(8'hfe, 1'b0, 8'h0f, 1'b1);
    mem(FE, 16'h8400, 8'h00, SR);
    mem(DR, 16'h87ff, 8'h00, SR);
    rw(8'hfe, 1'b0, 8'h17, 1'b1);
    mem(FE, 16'hf800, 8'h00, BT);
    mem(CR, 16'hffff, 8'h00, BT);
    rw(8'hfe, 1'b0, 8'h07, 1'b1);
    rw(8'h10, 1'b0, 8'h3c, 1'b0);
    rw(8'h90, 1'b1, 8'hc3, 1'b0);
    rr(8'h10, 1'b0, 8'h3c);
    rr(8'h90, 1'b1, 8'hc3);
    rr(8'h90, 1'b0, 8'h00);
    $display("test reloc boot scratch done");
  endtask : t_misc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // main sequence after ten reset cycles
  initial begin
    // a real falling edge, so the reset branches run at time zero
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_map();
    t_part();
    t_ext();
    t_write();
    t_misc();
    end_sim();
  end

  // watchdog, far beyond the 160 or so cycles needed
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule : memory_map_decoder_tb
`default_nettype wire

// file: mmd_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // command from the bench
  input wire logic [2:0] op_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  // request to the decoder
  output mmd_pkg::mmd_req_t req_o
);
  logic [15:0] last_r;
  // last address, so an idle bus never shows a stale value
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_r <= 16'h0000;
    end else if (op_i != 3'h0) begin
      last_r <= addr_i;
    end
  end
  always_comb begin
    req_o.fetch = (op_i == 3'h1);
    req_o.code_rd = (op_i == 3'h2);
    req_o.data_rd = (op_i == 3'h3);
    req_o.data_wr = (op_i == 3'h4);
    req_o.addr = (op_i == 3'h0) ? ~last_r : addr_i;
    req_o.wdata = (op_i == 3'h4) ? wdata_i : ~wdata_i;
  end
endmodule : mmd_core_model
`default_nettype wire

// file: mmd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module mmd_decoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // mode
  input wire logic prog_mode_i,
  input wire logic ext_only_i,
  // memory request
  input wire mmd_pkg::mmd_req_t req_i,
  output logic [5:0] tgt_o,
  output logic [15:0] maddr_o,
  output logic wr_ok_o,
  output logic wr_block_o,
  output logic ext_cyc_o,
  output logic [7:0] port_lo_o,
  // register space
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_ind_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hw_config_reg_zero;
    logic [7:0] hw_config_reg_one;
    logic [7:0] memory_write_select_reg;
    mmd_pkg::mmd_dec_t dec;
    logic [7:0] rdata;
  } mmd_st_t;

  mmd_st_t st_r;
  mmd_st_t st_nxt;
  logic [7:0] scratch [0:255];
  logic [16:0] pm_size;
  logic [16:0] dm_size;
  logic [2:0] part;
  logic sc_wr;

  // partition table, sizes in bytes
  always_comb begin
    part = st_r.hw_config_reg_zero[mmd_pkg::PART_LSB +: 3];
    unique case (part)
      3'h0, 3'h1: pm_size = 17'h00000;
      3'h2: pm_size = 17'h04000;
      3'h3: pm_size = 17'h06000;
      3'h4: pm_size = 17'h07000;
      3'h5: pm_size = 17'h07800;
      3'h6: pm_size = 17'h07c00;
      default: pm_size = mmd_pkg::FLASH_SIZE;
    endcase
    dm_size = mmd_pkg::FLASH_SIZE - pm_size;
  end

  // decode and register next state
  always_comb begin
    logic [16:0] a;
    logic in_pm;
    logic in_dm;
    logic in_sram;
    logic in_boot;
    logic pwr_lock;
    logic is_wr;
    logic is_data;
    logic is_code;
    logic ext_en;
    logic [16:0] dend;
    logic [16:0] sram_lo;
    logic reloc;
    a = {1'b0, req_i.addr};
    pwr_lock = 1'b0;
    st_nxt = st_r;
    reloc = st_r.hw_config_reg_zero[mmd_pkg::RELOC_BIT];
    is_code = req_i.fetch | req_i.code_rd;
    is_data = req_i.data_rd | req_i.data_wr;
    is_wr = req_i.data_wr;
    sram_lo = reloc ? {1'b0, mmd_pkg::SRAM_RELOC_BASE} : {1'b0, mmd_pkg::SRAM_BASE};
    in_sram = (a >= sram_lo) && (a < sram_lo + {1'b0, mmd_pkg::SRAM_SIZE})
      && (is_data || reloc);
    in_pm = !ext_only_i && (a < pm_size);
    dend = {1'b0, mmd_pkg::DFLASH_BASE} + dm_size;
    in_dm = (a >= {1'b0, mmd_pkg::DFLASH_BASE}) && (a < dend);
    in_boot = st_r.hw_config_reg_zero[mmd_pkg::BOOT_BIT] && !prog_mode_i
      && (a >= {1'b0, mmd_pkg::BOOT_BASE});
    // external bus only with both bits clear
    ext_en = (st_r.hw_config_reg_one[1:0] == 2'b00);
    st_nxt.dec.addr = req_i.addr;
    st_nxt.dec.wr_ok = 1'b0;
    st_nxt.dec.wr_block = 1'b0;
    st_nxt.dec.tgt = mmd_pkg::MMD_T_NONE;
    // code and data spaces decoded apart
    if (is_code) begin
      // fetches never served from data flash
      if (in_boot) begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_BOOT;
      end else if (in_sram) begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_SRAM;
      end else if (in_pm) begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_PFLASH;
      end else begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_EXT;
      end
    end else if (is_data) begin
      if (in_sram) begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_SRAM;
        st_nxt.dec.wr_ok = is_wr;
      end else if (in_dm || (a < pm_size)) begin
        st_nxt.dec.tgt = in_dm ? mmd_pkg::MMD_T_DFLASH : mmd_pkg::MMD_T_PFLASH;
        pwr_lock = !prog_mode_i && !in_dm && (st_r.hw_config_reg_zero[mmd_pkg::PWR_DIS_BIT]
          || (st_r.hw_config_reg_zero[mmd_pkg::LOCK_EN_BIT] && (st_r.hw_config_reg_zero[mmd_pkg::LOCK_ALL_BIT]
          || a < {1'b0, mmd_pkg::LOCK_SMALL_SIZE})));
        st_nxt.dec.wr_ok = is_wr && st_r.memory_write_select_reg[mmd_pkg::WSEL_BIT] && !pwr_lock;
        st_nxt.dec.wr_block = is_wr && !st_nxt.dec.wr_ok;
      end else begin
        st_nxt.dec.tgt = mmd_pkg::MMD_T_EXT;
      end
    end
    // registered here so the external-cycle flag leaves a flip-flop
    st_nxt.dec.ext_en = ext_en && (st_nxt.dec.tgt == mmd_pkg::MMD_T_EXT);
    // internal data hidden, port low byte zero
    // ports left as general purpose never show write data
    if (st_nxt.dec.tgt == mmd_pkg::MMD_T_EXT && is_wr && ext_en) begin
      st_nxt.dec.port_lo = req_i.wdata;
    end else begin
      st_nxt.dec.port_lo = 8'h00;
    end
    // config registers only in programming mode
    if (reg_wr_i && !reg_ind_i && prog_mode_i && reg_addr_i == mmd_pkg::SFR_HW_CONFIG_REG_ZERO) begin
      st_nxt.hw_config_reg_zero = reg_wdata_i;
    end
    if (reg_wr_i && !reg_ind_i && prog_mode_i && reg_addr_i == mmd_pkg::SFR_HW_CONFIG_REG_ONE) begin
      st_nxt.hw_config_reg_one = reg_wdata_i;
    end
    if (reg_wr_i && !reg_ind_i && reg_addr_i == mmd_pkg::SFR_MWS) begin
      st_nxt.memory_write_select_reg = reg_wdata_i;
    end
    // direct upper half hits special regs
    st_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_ind_i || reg_addr_i < mmd_pkg::SFR_BASE) begin
        st_nxt.rdata = scratch[reg_addr_i];
      end else if (reg_addr_i == mmd_pkg::SFR_HW_CONFIG_REG_ZERO) begin
        st_nxt.rdata = st_r.hw_config_reg_zero;
      end else if (reg_addr_i == mmd_pkg::SFR_HW_CONFIG_REG_ONE) begin
        st_nxt.rdata = st_r.hw_config_reg_one;
      end else if (reg_addr_i == mmd_pkg::SFR_MWS) begin
        st_nxt.rdata = st_r.memory_write_select_reg;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  assign sc_wr = ce_i && reg_wr_i && (reg_ind_i || reg_addr_i < mmd_pkg::SFR_BASE);
  always_ff @(posedge clk_i) begin
    if (sc_wr) begin
      scratch[reg_addr_i] <= reg_wdata_i;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r.hw_config_reg_zero <= mmd_pkg::HW_CONFIG_REG_ZERO_RST;
      st_r.hw_config_reg_one <= mmd_pkg::HW_CONFIG_REG_ONE_RST;
      st_r.memory_write_select_reg <= mmd_pkg::MWS_RST;
      st_r.dec <= '{tgt: mmd_pkg::MMD_T_NONE, addr: 16'h0000, wr_ok: 1'b0,
        wr_block: 1'b0, ext_en: 1'b0, port_lo: 8'h00};
      st_r.rdata <= 8'h00;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign tgt_o = st_r.dec.tgt;
  assign maddr_o = st_r.dec.addr;
  assign wr_ok_o = st_r.dec.wr_ok;
  assign wr_block_o = st_r.dec.wr_block;
  assign ext_cyc_o = st_r.dec.ext_en;
  assign port_lo_o = st_r.dec.port_lo;
  assign reg_rdata_o = st_r.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // ---------------------------------------------------------------
  // request sequences
  // ---------------------------------------------------------------
  // every request is one enabled cycle, answered one cycle later
  sequence fetch_s; ce_i && req_i.fetch; endsequence
  sequence code_s; ce_i && (req_i.fetch || req_i.code_rd); endsequence
  sequence data_rd_s; ce_i && req_i.data_rd; endsequence
  sequence data_wr_s; ce_i && req_i.data_wr; endsequence
  sequence idle_s; ce_i && !(req_i.fetch || req_i.code_rd || req_i.data_rd || req_i.data_wr);
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // config zero guard
  cfg_write_guard_a: assert property (!prog_mode_i && ce_i |=> $stable(st_r.hw_config_reg_zero))
    else $error("config register changed outside programming mode");

  cfg_one_guard_a: assert property (!prog_mode_i && ce_i |=> $stable(st_r.hw_config_reg_one))
    else $error("config register one changed outside programming mode");

  cfg_read_back_a: assert property (ce_i && reg_rd_i && !reg_ind_i && reg_addr_i == 8'hfe
    |=> reg_rdata_o == $past(st_r.hw_config_reg_zero))
    else $error("config register readback wrong");

  undef_read_zero_a: assert property (ce_i && reg_rd_i && !reg_ind_i && reg_addr_i == 8'h90
    |=> reg_rdata_o == 8'h00)
    else $error("undefined special register read not zero");

  read_one_cycle_a: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data stands without a read strobe");

  no_data_fetch_a: assert property (ce_i && req_i.fetch |=> tgt_o != 6'b000010)
    else $error("fetch served from data flash");

  flash_wsel_a: assert property (ce_i && req_i.data_wr && !st_r.memory_write_select_reg[0]
    |=> !(wr_ok_o && tgt_o != 6'b000100))
    else $error("flash write without write select");

  wr_pair_a: assert property (!(wr_ok_o && wr_block_o))
    else $error("write both allowed and refused");

  port_hidden_a: assert property (##1 tgt_o != 6'b010000 |-> port_lo_o == 8'h00)
    else $error("internal cycle shows data on port");

  sram_hidden_a: assert property (data_wr_s ##0 (!st_r.hw_config_reg_zero[3] && req_i.addr < 16'h0400)
    |=> port_lo_o == 8'h00)
    else $error("sram write data shown on port");

  ext_gate_a: assert property (ce_i && st_r.hw_config_reg_one[1:0] != 2'b00 |=> !ext_cyc_o)
    else $error("external cycle while ports are general purpose");

  ext_cycle_on_a: assert property (data_wr_s ##0 (st_r.hw_config_reg_one[1:0] == 2'b00
    && st_r.hw_config_reg_zero[3:0] == 4'h7 && req_i.addr >= 16'h9000 && req_i.addr < 16'hf000)
    |=> ext_cyc_o)
    else $error("external write without external cycle");

  zero_pm_a: assert property (ce_i && req_i.fetch && st_r.hw_config_reg_zero[2:1] == 2'b00
    && !st_r.hw_config_reg_zero[4] && !st_r.hw_config_reg_zero[3] |=> tgt_o == 6'b010000)
    else $error("fetch not external with zero program flash");

  ext_only_a: assert property (fetch_s ##0 (ext_only_i && !st_r.hw_config_reg_zero[3]
    && req_i.addr < 16'h8000) |=> tgt_o == 6'b010000)
    else $error("fetch internal while all fetches external");

  pm_top_a: assert property (fetch_s ##0 (st_r.hw_config_reg_zero[3:0] == 4'h6
    && req_i.addr >= 16'h7c00 && req_i.addr < 16'h8000) |=> tgt_o == 6'b010000)
    else $error("fetch above program partition not external");

  sram_low_a: assert property (ce_i && req_i.data_rd && !st_r.hw_config_reg_zero[3]
    && req_i.addr < 16'h0400 |=> tgt_o == 6'b000100)
    else $error("low data address missed sram");

  sram_write_a: assert property (data_wr_s ##0 (!st_r.hw_config_reg_zero[3] && req_i.addr < 16'h0400)
    |=> wr_ok_o && tgt_o == 6'b000100)
    else $error("sram write refused");

  reloc_sram_a: assert property (code_s ##0 (st_r.hw_config_reg_zero[3] && req_i.addr >= 16'h8400
    && req_i.addr < 16'h8800) |=> tgt_o == 6'b000100)
    else $error("relocated sram missed by code access");

  boot_map_a: assert property (code_s ##0 (st_r.hw_config_reg_zero[4] && !prog_mode_i
    && req_i.addr >= 16'hf800) |=> tgt_o == 6'b001000)
    else $error("boot rom window missed");

  dflash_map_a: assert property (data_rd_s ##0 (st_r.hw_config_reg_zero[2:0] == 3'h6
    && req_i.addr >= 16'h0400 && req_i.addr < 16'h0800) |=> tgt_o == 6'b000010)
    else $error("data flash window missed");

  lock_small_a: assert property (ce_i && !prog_mode_i && req_i.data_wr && st_r.hw_config_reg_zero[5]
    && req_i.addr < 16'h1000 && req_i.addr >= 16'h0400 && st_r.hw_config_reg_zero[2:0] == 3'h7
    |=> !wr_ok_o)
    else $error("locked program flash write allowed");

  pdis_block_a: assert property (data_wr_s ##0 (!prog_mode_i && st_r.hw_config_reg_zero[7]
    && st_r.hw_config_reg_zero[3:0] == 4'h7 && req_i.addr >= 16'h0400 && req_i.addr < 16'h8000)
    |=> wr_block_o)
    else $error("disabled program flash write allowed");

  dflash_free_a: assert property (data_wr_s ##0 (st_r.memory_write_select_reg[0] && st_r.hw_config_reg_zero[2:0] == 3'h6
    && req_i.addr >= 16'h0400 && req_i.addr < 16'h0800) |=> wr_ok_o)
    else $error("data flash write refused");

  addr_follow_a: assert property (ce_i |=> maddr_o == $past(req_i.addr))
    else $error("decoded address does not follow request");

  idle_none_a: assert property (idle_s |=> tgt_o == 6'b100000)
    else $error("idle cycle decoded to a target");

  // clock enable freezes the answer
  ce_freeze_a: assert property (!ce_i |=> $stable(tgt_o) && $stable(maddr_o)
    && $stable(reg_rdata_o))
    else $error("outputs moved while clock enable low");

endmodule : mmd_decoder
`default_nettype wire

// file: mmd_pkg.sv
//
// Contract
// - undefined special register reads return zero
// - config registers writable only in programming mode
// - lock blocks program flash writes, 4kB or all
// - sram defaults at data address zero
// - relocated sram at 8400 for code and data
// - separate 64kB program and data spaces
// - outside internal range goes to external port
// - partition code selects program/data flash split
// - zero program flash sends fetches external
// - data flash sits at 0400 above sram
// - smaller program partition shrinks from top
// - data-move flash writes need write select bit
// - never fetch from data flash
// - config bit disables program flash writes only
// - internal data never shown on external port
// - 256 byte scratchpad in register space
// - direct 00-7f reaches lower scratchpad
// - direct 80-ff special regs, indirect upper scratchpad
// - port low byte zero during internal data phase
// - external bus only when cfg one bits clear
// - boot rom at f800-ffff in user mode
package mmd_pkg;

  // ---------------------------------------------------------------
  // memory map constants
  // ---------------------------------------------------------------
  localparam logic [15:0] SRAM_BASE = 16'h0000;
  localparam logic [15:0] SRAM_RELOC_BASE = 16'h8400;
  localparam logic [15:0] SRAM_SIZE = 16'h0400;
  localparam logic [15:0] DFLASH_BASE = 16'h0400;
  localparam logic [15:0] BOOT_BASE = 16'hf800;
  localparam logic [15:0] LOCK_SMALL_SIZE = 16'h1000;
  localparam logic [16:0] FLASH_SIZE = 17'h08000;

  // ---------------------------------------------------------------
  // special register offsets of this block
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_MWS = 8'h8f;
  localparam logic [7:0] SFR_HW_CONFIG_REG_ZERO = 8'hfe;
  localparam logic [7:0] SFR_HW_CONFIG_REG_ONE = 8'hff;
  localparam logic [7:0] SFR_BASE = 8'h80;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int PART_LSB = 0;
  localparam int RELOC_BIT = 3;
  localparam int BOOT_BIT = 4;
  localparam int LOCK_EN_BIT = 5;
  localparam int LOCK_ALL_BIT = 6;
  localparam int PWR_DIS_BIT = 7;
  localparam int WSEL_BIT = 0;
  localparam logic [7:0] HW_CONFIG_REG_ZERO_RST = 8'h07;
  localparam logic [7:0] HW_CONFIG_REG_ONE_RST = 8'h03;
  localparam logic [7:0] MWS_RST = 8'h00;

  // ---------------------------------------------------------------
  // access target encoding
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    MMD_T_PFLASH = 6'b000001,
    MMD_T_DFLASH = 6'b000010,
    MMD_T_SRAM = 6'b000100,
    MMD_T_BOOT = 6'b001000,
    MMD_T_EXT = 6'b010000,
    MMD_T_NONE = 6'b100000
  } mmd_tgt_t;

  // memory request from the core
  typedef struct packed {
    logic fetch;
    logic code_rd;
    logic data_rd;
    logic data_wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmd_req_t;

  // decoded answer
  typedef struct packed {
    mmd_tgt_t tgt;
    logic [15:0] addr;
    logic wr_ok;
    logic wr_block;
    logic ext_en;
    logic [7:0] port_lo;
  } mmd_dec_t;

endpackage : mmd_pkg
